/* File: core/csc_defs.vh */
// Register map, field positions, reset values and timing counts of the clock source control
`ifndef CSC_DEFS_VH
`define CSC_DEFS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CSC_SUPPLY_CTRL_REG 8'h00
`define CSC_SUPPLY_MODE_REG 8'h04
`define CSC_SUPPLY_STATUS_REG 8'h08
`define CSC_MAIN_OSC_CTRL_REG 8'h0c
`define CSC_PM_STATUS_REG 8'h10
`define CSC_PM_IRQ_MASK_REG 8'h14
`define CSC_OSC_CALIB_REG 8'h18
`define CSC_MAIN_FREQ_MEAS_REG 8'h1c

// ****************************************
// Field positions
// ****************************************
`define CSC_SLOW_XTAL_SELECT_BIT 3
`define CSC_SLOW_OSC_BYPASS_BIT 20
`define CSC_SUPPLY_SLOW_SRC_BIT 7
`define CSC_MAIN_XTAL_ENABLE_BIT 0
`define CSC_FAST_RC_ENABLE_BIT 3
`define CSC_FAST_RC_FREQ_LSB 4
`define CSC_XTAL_STARTUP_LSB 8
`define CSC_MAIN_SRC_SELECT_BIT 24
`define CSC_MAIN_XTAL_STABLE_BIT 0
`define CSC_PM_SLOW_SRC_BIT 7
`define CSC_MAIN_SWITCH_DONE_BIT 16
`define CSC_FAST_RC_STABLE_BIT 17
`define CSC_TRIM_FIELD_STRIDE 8
`define CSC_MEAS_READY_BIT 16
`define CSC_MEAS_RESTART_BIT 20

// ****************************************
// Codes and reset values
// ****************************************
`define CSC_FREQ_LOW 2'h0
`define CSC_FREQ_MID 2'h1
`define CSC_FREQ_HIGH 2'h2
`define CSC_FREQ_RESERVED 2'h3
`define CSC_XTAL_STARTUP_RESET 8'h00
`define CSC_OSC_CALIB_RESET 24'h000000

// ****************************************
// Timing counts, in slow clock periods
// ****************************************
`define CSC_XTAL_TICK_DIV 3'h7
`define CSC_MEAS_PERIODS 5'h10
`define CSC_FAST_RC_SETTLE 8'h04
`define CSC_SLOW_XTAL_SETTLE 8'h08

`endif

/* File: core/csc_down_timer.v */
// Reloadable down counter that expires after a number of tick pulses
`timescale 1ns/1ns
`default_nettype none

module csc_down_timer #(
	parameter WIDTH = 8
) (
	input wire clk,
	input wire rst_n,
	input wire clear,
	input wire load,
	input wire [WIDTH-1:0] loadValue,
	input wire tick,
	output wire expired
);

reg armed;
reg [WIDTH-1:0] count;

// Load beats clear: the enabling write lands while the enable still reads low
always @(posedge clk)
begin
	if (!rst_n)
	begin
		armed <= 1'b0;
		count <= {WIDTH{1'b0}};
	end
	else if (load)
	begin
		armed <= 1'b1;
		count <= loadValue;
	end
	else if (clear)
	begin
		armed <= 1'b0;
		count <= {WIDTH{1'b0}};
	end
	else if (tick && armed && count != {WIDTH{1'b0}})
		count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
end

// Zero loaded means expiry on the next cycle
assign expired = armed && (count == {WIDTH{1'b0}});

endmodule

`default_nettype wire

/* File: core/csc_clock_ctrl.v */
// Clock source control: slow and main oscillator selection, trims, start-up and measurement
// Behaviour
// - At I/O supply rise, RC slow oscillator enabled and selected; crystal oscillator off, idle
// - Slow select bit in supply control; selected source shown in both status registers
// - Power status slow-source bit sets only after the switch sequence completes
// - Select sequence: pins to oscillator, crystal on, then RC off, glitch-free
// - Crystal slow selection is permanent until the I/O supply is removed
// - Slow crystal pins are pulled-up general inputs until the sequence takes them
// - After reset the fast RC runs at 4 MHz and feeds the main clock
// - Fast RC enable bit in the main oscillator control register switches it
// - Fast RC frequency change clears stable, stops main clock until settled
// - Clearing the fast RC enable clears the fast RC stable flag
// - Interrupt enable for fast RC stable raises the interrupt line
// - Factory trims are inputs; user trims return to zero on every rst_n reset, not on supply reset
// - Per-frequency select chooses factory trim or user trim field
// - Trim of the frequency currently running is never altered
// - Restart bit starts a measurement; ready flag then count readable
// - Main crystal is disabled and not selected after reset
// - Clearing the main crystal enable clears the crystal stable flag
// - Crystal enable write takes pins, clears stable, counts down on slow/8
// - Counter at zero sets crystal stable; mask bit raises interrupt
// - Main source switch between RC and crystal is glitch-free, sets done flag
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "csc_defs.vh"

module csc_clock_ctrl #(
	parameter TRIM_WIDTH = 7,
	parameter MEAS_WIDTH = 16
) (
	input wire clk,
	input wire rst_n,
	input wire supplyRst_n,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	input wire slowClkIn,
	input wire mainClkIn,
	input wire [TRIM_WIDTH-1:0] factoryTrimLow,
	input wire [TRIM_WIDTH-1:0] factoryTrimMid,
	input wire [TRIM_WIDTH-1:0] factoryTrimHigh,
	output reg slowRcEn,
	output reg slowXtalOscEn,
	output reg slowXtalPinsOsc,
	output reg slowXtalPinPullup,
	output reg slowOscBypass,
	output reg slowClkSelXtal,
	output reg fastRcEn,
	output reg [1:0] fastRcFreq,
	output reg [TRIM_WIDTH-1:0] fastRcTrim,
	output reg mainXtalEn,
	output wire mainXtalPinsOsc,
	output reg mainSrcXtal,
	output reg mainClkRun,
	output reg irq
);

// ****************************************
// Helpers
// ****************************************

// Byte-lane merge for Wishbone writes
function [31:0] laneMerge;
	input [31:0] oldValue;
	input [31:0] newValue;
	input [3:0] lanes;
	integer i;
	begin
		laneMerge = oldValue;
		for (i = 0; i < 4; i = i + 1)
			if (lanes[i])
				laneMerge[i*8 +: 8] = newValue[i*8 +: 8];
	end
endfunction

// Trim actually driven: user field only when its select bit is set
function [TRIM_WIDTH-1:0] pickTrim;
	input useUser;
	input [TRIM_WIDTH-1:0] userTrim;
	input [TRIM_WIDTH-1:0] factoryTrim;
	begin
		pickTrim = useUser ? userTrim : factoryTrim;
	end
endfunction

// ****************************************
// Bus slave
// ****************************************
wire busReq = cyc_i && stb_i;
wire wrNow = busReq && we_i && ack_o;
wire [31:0] wrData = laneMerge(32'h00000000, dat_i, sel_i);
wire wrSupplyCtrl = wrNow && adr_i == `CSC_SUPPLY_CTRL_REG;
wire wrSupplyMode = wrNow && adr_i == `CSC_SUPPLY_MODE_REG;
wire wrMainOsc = wrNow && adr_i == `CSC_MAIN_OSC_CTRL_REG;
wire wrIrqMask = wrNow && adr_i == `CSC_PM_IRQ_MASK_REG;
wire wrCalib = wrNow && adr_i == `CSC_OSC_CALIB_REG;
wire wrMeas = wrNow && adr_i == `CSC_MAIN_FREQ_MEAS_REG;

reg [7:0] xtalStartup;
reg mainSrcSelect;
reg [31:0] irqMask;
reg [23:0] oscCalib;
reg fastRcStable;
reg mainXtalStable;
reg mainSwitchDone;
reg pmSlowSrc;
reg measReady;
reg [MEAS_WIDTH-1:0] measCount;

wire [31:0] mainOscWord = ({31'h0, mainXtalEn} << `CSC_MAIN_XTAL_ENABLE_BIT)
	| ({31'h0, fastRcEn} << `CSC_FAST_RC_ENABLE_BIT)
	| ({30'h0, fastRcFreq} << `CSC_FAST_RC_FREQ_LSB)
	| ({24'h0, xtalStartup} << `CSC_XTAL_STARTUP_LSB)
	| ({31'h0, mainSrcSelect} << `CSC_MAIN_SRC_SELECT_BIT);
wire [31:0] pmStatusWord = ({31'h0, mainXtalStable} << `CSC_MAIN_XTAL_STABLE_BIT)
	| ({31'h0, pmSlowSrc} << `CSC_PM_SLOW_SRC_BIT)
	| ({31'h0, mainSwitchDone} << `CSC_MAIN_SWITCH_DONE_BIT)
	| ({31'h0, fastRcStable} << `CSC_FAST_RC_STABLE_BIT);

// Ack one cycle after the request, dropped the cycle after; unmapped reads give zero
always @(posedge clk)
begin
	if (!rst_n)
	begin
		ack_o <= 1'b0;
		dat_o <= 32'h00000000;
	end
	else
	begin
		ack_o <= busReq && !ack_o;
		if (busReq && !ack_o)
		begin
			case (adr_i)
				`CSC_SUPPLY_CTRL_REG: dat_o <= 32'h00000000;
				`CSC_SUPPLY_MODE_REG: dat_o <= {31'h0, slowOscBypass} << `CSC_SLOW_OSC_BYPASS_BIT;
				`CSC_SUPPLY_STATUS_REG: dat_o <= {31'h0, slowClkSelXtal} << `CSC_SUPPLY_SLOW_SRC_BIT;
				`CSC_MAIN_OSC_CTRL_REG: dat_o <= mainOscWord;
				`CSC_PM_STATUS_REG: dat_o <= pmStatusWord;
				`CSC_PM_IRQ_MASK_REG: dat_o <= irqMask;
				`CSC_OSC_CALIB_REG: dat_o <= {8'h00, oscCalib};
				`CSC_MAIN_FREQ_MEAS_REG: dat_o <= {15'h0000, measReady, measCount};
				default: dat_o <= 32'h00000000;
			endcase
		end
	end
end

// ****************************************
// Slow clock tick generation
// ****************************************
reg slowSync1;
reg slowSync2;
reg slowPrev;
reg [2:0] slowDiv;
wire slowFall = slowPrev && !slowSync2;
wire slowDiv8Tick = slowFall && slowDiv == `CSC_XTAL_TICK_DIV;

// Two stages before the edge detector; the divider gives the slow/8 tick
always @(posedge clk)
begin
	if (!rst_n)
	begin
		slowSync1 <= 1'b0;
		slowSync2 <= 1'b0;
		slowPrev <= 1'b0;
		slowDiv <= 3'h0;
	end
	else
	begin
		slowSync1 <= slowClkIn;
		slowSync2 <= slowSync1;
		slowPrev <= slowSync2;
		if (slowFall)
			slowDiv <= slowDiv + 3'h1;
	end
end

// ****************************************
// Slow clock source sequence
// ****************************************
localparam SL_RC = 3'h0;
localparam SL_PINS = 3'h1;
localparam SL_XTAL_ON = 3'h2;
localparam SL_SWITCH = 3'h3;
localparam SL_RC_OFF = 3'h4;
localparam SL_DONE = 3'h5;

reg [2:0] slowState;
reg [7:0] slowWait;

// Only the supply reset returns here, so the peripheral reset cannot undo the crystal
always @(posedge clk)
begin
	if (!supplyRst_n)
	begin
		slowState <= SL_RC;
		slowWait <= 8'h00;
		slowRcEn <= 1'b1;
		slowXtalOscEn <= 1'b0;
		slowXtalPinsOsc <= 1'b0;
		slowXtalPinPullup <= 1'b1;
		slowClkSelXtal <= 1'b0;
		slowOscBypass <= 1'b0;
		pmSlowSrc <= 1'b0;
	end
	else
	begin
		// Bypass is only meaningful before the select, later writes are dropped
		if (wrSupplyMode && slowState == SL_RC)
			slowOscBypass <= wrData[`CSC_SLOW_OSC_BYPASS_BIT];
		case (slowState)
			SL_RC:
				if (wrSupplyCtrl && wrData[`CSC_SLOW_XTAL_SELECT_BIT])
					slowState <= SL_PINS;
			SL_PINS:
			begin
				slowXtalPinsOsc <= 1'b1;
				slowXtalPinPullup <= 1'b0;
				slowState <= SL_XTAL_ON;
				slowWait <= `CSC_SLOW_XTAL_SETTLE;
			end
			SL_XTAL_ON:
			begin
				slowXtalOscEn <= 1'b1;
				if (slowFall)
				begin
					if (slowWait == 8'h00)
						slowState <= SL_SWITCH;
					else
						slowWait <= slowWait - 8'h01;
				end
			end
			SL_SWITCH:
				// Mux flips right after a falling edge, while both sources are low-going
				if (slowFall)
				begin
					slowClkSelXtal <= 1'b1;
					slowState <= SL_RC_OFF;
				end
			SL_RC_OFF:
			begin
				slowRcEn <= 1'b0;
				slowState <= SL_DONE;
			end
			SL_DONE:
				pmSlowSrc <= 1'b1;
			default:
				slowState <= SL_RC;
		endcase
	end
end

// ****************************************
// Main oscillator control register
// ****************************************
wire newRcEn = wrData[`CSC_FAST_RC_ENABLE_BIT];
wire [1:0] newFreq = wrData[`CSC_FAST_RC_FREQ_LSB +: 2];
wire newXtalEn = wrData[`CSC_MAIN_XTAL_ENABLE_BIT];
wire freqChange = wrMainOsc && fastRcEn && newRcEn && newFreq != fastRcFreq
	&& newFreq != `CSC_FREQ_RESERVED;
wire xtalStart = wrMainOsc && newXtalEn;

// Frequency is only taken while the RC already runs; enable and change together is refused
always @(posedge clk)
begin
	if (!rst_n)
	begin
		fastRcEn <= 1'b1;
		fastRcFreq <= `CSC_FREQ_LOW;
		mainXtalEn <= 1'b0;
		xtalStartup <= `CSC_XTAL_STARTUP_RESET;
		mainSrcSelect <= 1'b0;
		irqMask <= 32'h00000000;
	end
	else
	begin
		if (wrMainOsc)
		begin
			fastRcEn <= newRcEn;
			mainXtalEn <= newXtalEn;
			xtalStartup <= wrData[`CSC_XTAL_STARTUP_LSB +: 8];
			mainSrcSelect <= wrData[`CSC_MAIN_SRC_SELECT_BIT];
			if (freqChange)
				fastRcFreq <= newFreq;
		end
		if (wrIrqMask)
			irqMask <= laneMerge(irqMask, dat_i, sel_i);
	end
end

assign mainXtalPinsOsc = mainXtalEn;

// ****************************************
// Start-up timers
// ****************************************
wire rcSettled;
wire xtalCounted;

csc_down_timer #(.WIDTH(8)) fastRcTimer (
	.clk(clk),
	.rst_n(rst_n),
	.clear(!fastRcEn),
	.load(freqChange || (wrMainOsc && newRcEn && !fastRcEn)),
	.loadValue(`CSC_FAST_RC_SETTLE),
	.tick(slowFall),
	.expired(rcSettled)
);

csc_down_timer #(.WIDTH(8)) xtalTimer (
	.clk(clk),
	.rst_n(rst_n),
	.clear(!mainXtalEn),
	.load(xtalStart),
	.loadValue(wrData[`CSC_XTAL_STARTUP_LSB +: 8]),
	.tick(slowDiv8Tick),
	.expired(xtalCounted)
);

// Stable flags: writes that restart an oscillator clear, the timers set
always @(posedge clk)
begin
	if (!rst_n)
	begin
		fastRcStable <= 1'b1;
		mainXtalStable <= 1'b0;
	end
	else
	begin
		if (!fastRcEn || freqChange)
			fastRcStable <= 1'b0;
		else if (rcSettled)
			fastRcStable <= 1'b1;
		if (!mainXtalEn || xtalStart)
			mainXtalStable <= 1'b0;
		else if (xtalCounted)
			mainXtalStable <= 1'b1;
	end
end

// ****************************************
// Main clock source switch
// ****************************************
wire targetStable = mainSrcSelect ? mainXtalStable : fastRcStable;

// Switch on a slow edge once the target runs; done holds off while they differ
always @(posedge clk)
begin
	if (!rst_n)
	begin
		mainSrcXtal <= 1'b0;
		mainSwitchDone <= 1'b1;
		mainClkRun <= 1'b0;
	end
	else
	begin
		if (mainSrcXtal != mainSrcSelect && targetStable && slowFall)
			mainSrcXtal <= mainSrcSelect;
		mainSwitchDone <= mainSrcXtal == mainSrcSelect;
		mainClkRun <= mainSrcXtal ? mainXtalStable : fastRcStable;
	end
end

// ****************************************
// Trims
// ****************************************
wire [1:0] freqInUse = fastRcFreq;

// Field of the running frequency is write-protected, including its select bit
always @(posedge clk)
begin
	if (!rst_n)
		oscCalib <= `CSC_OSC_CALIB_RESET;
	else if (wrCalib)
	begin
		if (freqInUse != `CSC_FREQ_LOW && sel_i[0])
			oscCalib[7:0] <= dat_i[7:0];
		if (freqInUse != `CSC_FREQ_MID && sel_i[1])
			oscCalib[15:8] <= dat_i[15:8];
		if (freqInUse != `CSC_FREQ_HIGH && sel_i[2])
			oscCalib[23:16] <= dat_i[23:16];
	end
end

// Trim presented to the analogue RC for the running frequency
always @(posedge clk)
begin
	if (!rst_n)
		fastRcTrim <= factoryTrimLow;
	else
	begin
		case (fastRcFreq)
			`CSC_FREQ_MID:
				fastRcTrim <= pickTrim(oscCalib[15], oscCalib[8 +: TRIM_WIDTH], factoryTrimMid);
			`CSC_FREQ_HIGH:
				fastRcTrim <= pickTrim(oscCalib[23], oscCalib[16 +: TRIM_WIDTH], factoryTrimHigh);
			default:
				fastRcTrim <= pickTrim(oscCalib[7], oscCalib[0 +: TRIM_WIDTH], factoryTrimLow);
		endcase
	end
end

// ****************************************
// Frequency measurement
// ****************************************
reg mainSync1;
reg mainSync2;
reg mainPrev;
reg measRun;
reg [4:0] measPeriods;
reg rcStablePrev;
reg xtalStablePrev;
reg srcPrev;
wire measStart = (wrMeas && wrData[`CSC_MEAS_RESTART_BIT])
	|| (fastRcStable && !rcStablePrev && !mainSrcXtal)
	|| (mainXtalStable && !xtalStablePrev && mainSrcXtal)
	|| (mainSrcXtal != srcPrev);

// Counts synchronised main clock rises over 16 slow periods; only sub-5 MHz is exact
always @(posedge clk)
begin
	if (!rst_n)
	begin
		mainSync1 <= 1'b0;
		mainSync2 <= 1'b0;
		mainPrev <= 1'b0;
		measRun <= 1'b0;
		measPeriods <= 5'h00;
		measReady <= 1'b0;
		measCount <= {MEAS_WIDTH{1'b0}};
		rcStablePrev <= 1'b0;
		xtalStablePrev <= 1'b0;
		srcPrev <= 1'b0;
	end
	else
	begin
		mainSync1 <= mainClkIn;
		mainSync2 <= mainSync1;
		mainPrev <= mainSync2;
		rcStablePrev <= fastRcStable;
		xtalStablePrev <= mainXtalStable;
		srcPrev <= mainSrcXtal;
		if (measStart)
		begin
			measRun <= 1'b1;
			measReady <= 1'b0;
			measPeriods <= 5'h00;
			measCount <= {MEAS_WIDTH{1'b0}};
		end
		else if (measRun)
		begin
			if (mainSync2 && !mainPrev)
				measCount <= measCount + {{(MEAS_WIDTH-1){1'b0}}, 1'b1};
			if (slowFall)
			begin
				measPeriods <= measPeriods + 5'h01;
				if (measPeriods + 5'h01 == `CSC_MEAS_PERIODS)
				begin
					measRun <= 1'b0;
					measReady <= 1'b1;
				end
			end
		end
	end
end

// ****************************************
// Interrupt line
// ****************************************

// Level interrupt from masked status flags
always @(posedge clk)
begin
	if (!rst_n)
		irq <= 1'b0;
	else
		irq <= |(pmStatusWord & irqMask);
end

endmodule

`default_nettype wire

/* File: tb/csc_checker.sv */
// Concurrent checks on the ports of the clock source control
`timescale 1ns/1ns
`default_nettype none
module csc_checker #(
	parameter TRIM_WIDTH = 7
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic supplyRst_n,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic slowRcEn,
	input wire logic slowXtalOscEn,
	input wire logic slowXtalPinsOsc,
	input wire logic slowXtalPinPullup,
	input wire logic slowClkSelXtal,
	input wire logic fastRcEn,
	input wire logic [1:0] fastRcFreq,
	input wire logic [TRIM_WIDTH-1:0] fastRcTrim,
	input wire logic mainXtalEn,
	input wire logic mainXtalPinsOsc,
	input wire logic mainSrcXtal
);
	// Main group packed so the reset check stays on one line
	wire [4:0] mainState = {fastRcEn, fastRcFreq, mainXtalEn, mainSrcXtal};

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n || !supplyRst_n);

	chk_slow_default: assert property ($rose(supplyRst_n) |-> slowRcEn && !slowClkSelXtal)
		else $error("slow source not on RC after supply reset");
	chk_xtal_first: assert property ($rose(slowClkSelXtal) |-> slowXtalOscEn && slowXtalPinsOsc)
		else $error("slow mux moved before crystal was ready");
	chk_rc_off_late: assert property ($fell(slowRcEn) |-> $past(slowClkSelXtal))
		else $error("RC stopped before the slow mux moved");
	chk_slow_one_way: assert property (slowClkSelXtal |=> slowClkSelXtal)
		else $error("slow source left the crystal");
	chk_pin_pullup: assert property (slowXtalPinPullup != slowXtalPinsOsc)
		else $error("slow pin pull-up does not match pin mode");
	chk_main_default: assert property ($rose(rst_n) |-> mainState == 5'h10)
		else $error("main oscillators not at reset state");
	chk_trim_held: assert property ($changed(fastRcTrim) |-> fastRcFreq != $past(fastRcFreq, 2))
		else $error("trim of running frequency changed");
	chk_xtal_pins: assert property (mainXtalPinsOsc == mainXtalEn)
		else $error("main crystal pins not following enable");
	chk_freq_code: assert property (fastRcFreq != 2'h3)
		else $error("reserved frequency code applied");
	chk_bus_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus answer missing or too long");

	// Main scenarios reached
	cover property ($rose(slowClkSelXtal));
	cover property ($rose(mainSrcXtal));
	cover property ($changed(fastRcTrim));
endmodule

bind csc_clock_ctrl csc_checker #(.TRIM_WIDTH(TRIM_WIDTH)) i_csc_checker (.clk(clk),
	.rst_n(rst_n), .supplyRst_n(supplyRst_n), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.slowRcEn(slowRcEn), .slowXtalOscEn(slowXtalOscEn), .slowXtalPinsOsc(slowXtalPinsOsc),
	.slowXtalPinPullup(slowXtalPinPullup), .slowClkSelXtal(slowClkSelXtal),
	.fastRcEn(fastRcEn), .fastRcFreq(fastRcFreq), .fastRcTrim(fastRcTrim),
	.mainXtalEn(mainXtalEn), .mainXtalPinsOsc(mainXtalPinsOsc), .mainSrcXtal(mainSrcXtal));
`default_nettype wire

/* File: tb/csc_osc_model.sv */
// Behavioural oscillators feeding the slow and main clock pins
`timescale 1ns/1ns
`default_nettype none
module csc_osc_model (
	input wire logic slowRcEn,
	input wire logic slowXtalOscEn,
	input wire logic fastRcEn,
	input wire logic mainXtalEn,
	input wire logic mainSrcXtal,
	output logic slowClkIn,
	output logic mainClkIn
);
	// Both pins idle low until an oscillator runs
	initial
	begin
		slowClkIn = 1'b0;
		mainClkIn = 1'b0;
	end

	// Slow clock scaled to 1.6 us so start-up counts stay short
	always #800 slowClkIn = (slowRcEn | slowXtalOscEn) & ~slowClkIn;

	// Main pin follows the selected source; a stopped source holds it low
	// Unknown select before reset must not give a zero delay loop
	always #((mainSrcXtal === 1'b1) ? 233 : 171) mainClkIn = (mainSrcXtal ? mainXtalEn : fastRcEn) & ~mainClkIn;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the clock source control
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk, rst_n, supplyRst_n, cyc_i, stb_i, we_i;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, rdv;
	logic [6:0] factoryTrimLow, factoryTrimMid, factoryTrimHigh;
	wire [31:0] dat_o;
	wire ack_o, slowClkIn, mainClkIn, slowRcEn, slowXtalOscEn, slowXtalPinsOsc;
	wire slowXtalPinPullup, slowOscBypass, slowClkSelXtal, fastRcEn, mainXtalEn;
	wire mainXtalPinsOsc, mainSrcXtal, mainClkRun, irq;
	wire [1:0] fastRcFreq;
	wire [6:0] fastRcTrim;
	int miscompares, comparisons;

	csc_clock_ctrl i_csc_clock_ctrl (.*);
	csc_osc_model i_csc_osc_model (.*);

	// 10 MHz system clock
	always #50 clk = ~clk;

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkb(input logic [7:0] got, input logic [7:0] exp);
		chk({24'h0, got}, {24'h0, exp});
	endtask

	// One classic cycle, held until ack is sampled; only the watchdog ends a hang
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hf;
		dat_i <= d;
		@(posedge clk);
		while (ack_o !== 1'b1)
			@(posedge clk);
		rdv = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(negedge clk);
	endtask

	// Poll a field up to lim extra reads, then compare it
	task automatic look(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input int lim);
		int n;
		n = 0;
		bus(1'b0, a, 32'h0);
		while ((rdv & m) !== e && n < lim)
		begin
			n++;
			bus(1'b0, a, 32'h0);
		end
		chk(rdv & m, e);
	endtask

	task automatic rstPulse(input logic p, input logic s);
		@(posedge clk);
		rst_n <= !p;
		supplyRst_n <= !s;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		supplyRst_n <= 1'b1;
		@(negedge clk);
	endtask

	task automatic irqCase(input logic [31:0] m, input logic e);
		bus(1'b1, 8'h14, m);
		look(8'h14, 32'hffffffff, m, 0);
		chkb({7'h0, irq}, {7'h0, e});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic tReset;
		chkb({3'h0, fastRcEn, fastRcFreq, mainXtalEn, mainSrcXtal}, 8'h10);
		look(8'h0c, 32'hffffffff, 32'h8, 0);
		chkb({4'h0, slowRcEn, slowXtalOscEn, slowClkSelXtal, slowXtalPinPullup}, 8'h09);
		chkb({1'h0, fastRcTrim}, 8'h05);
		look(8'h18, 32'hffffffff, 32'h0, 0);
		look(8'h10, 32'h10000, 32'h10000, 0);
		look(8'h10, 32'h20000, 32'h20000, 0);
		chkb({7'h0, mainClkRun}, 8'h1);
		bus(1'b1, 8'h20, 32'hffffffff);
		look(8'h20, 32'hffffffff, 32'h0, 0);
	endtask

	// User trims while running low, then move to mid, reserved, high
	task automatic tTrim;
		bus(1'b1, 8'h18, 32'h00b3a291);
		look(8'h18, 32'hffffffff, 32'h00b3a200, 0);
		chkb({1'h0, fastRcTrim}, 8'h05);
		bus(1'b1, 8'h0c, 32'h18);
		look(8'h10, 32'h20000, 32'h0, 0);
		chkb({7'h0, mainClkRun}, 8'h0);
		look(8'h10, 32'h20000, 32'h20000, 1500);
		chkb({7'h0, mainClkRun}, 8'h1);
		chkb({1'h0, fastRcTrim}, 8'h22);
		bus(1'b1, 8'h0c, 32'h38);
		chkb({6'h0, fastRcFreq}, 8'h1);
		bus(1'b1, 8'h0c, 32'h28);
		look(8'h10, 32'h20000, 32'h20000, 1500);
		chkb({1'h0, fastRcTrim}, 8'h33);
	endtask

	task automatic tRcOff;
		bus(1'b1, 8'h0c, 32'h20);
		chkb({7'h0, fastRcEn}, 8'h0);
		look(8'h10, 32'h20000, 32'h0, 0);
		bus(1'b1, 8'h0c, 32'h28);
		look(8'h10, 32'h20000, 32'h20000, 1500);
	endtask

	// Crystal start-up, interrupts, main switch both ways, measurement
	task automatic tXtal;
		bus(1'b1, 8'h0c, 32'h529);
		chkb({6'h0, mainXtalEn, mainXtalPinsOsc}, 8'h3);
		look(8'h10, 32'h1, 32'h0, 0);
		look(8'h10, 32'h1, 32'h1, 1500);
		irqCase(32'h1, 1'b1);
		irqCase(32'h20000, 1'b1);
		irqCase(32'h0, 1'b0);
		bus(1'b1, 8'h0c, 32'h01000529);
		look(8'h10, 32'h10000, 32'h0, 0);
		look(8'h10, 32'h10000, 32'h10000, 1500);
		chkb({7'h0, mainSrcXtal}, 8'h1);
		bus(1'b1, 8'h1c, 32'h00100000);
		look(8'h1c, 32'h10000, 32'h10000, 1500);
		chkb({7'h0, rdv[15:0] > 16'd49 && rdv[15:0] < 16'd57}, 8'h1);
		bus(1'b1, 8'h0c, 32'h529);
		look(8'h10, 32'h10000, 32'h10000, 1500);
		chkb({7'h0, mainSrcXtal}, 8'h0);
		bus(1'b1, 8'h0c, 32'h28);
		chkb({6'h0, mainXtalEn, mainXtalPinsOsc}, 8'h0);
		look(8'h10, 32'h1, 32'h0, 0);
	endtask

	// Bypass first, then the one-way slow switch; resets of both kinds
	task automatic tSlow;
		bus(1'b1, 8'h04, 32'h00100000);
		chkb({7'h0, slowOscBypass}, 8'h1);
		bus(1'b1, 8'h00, 32'h8);
		look(8'h10, 32'h80, 32'h0, 0);
		look(8'h10, 32'h80, 32'h80, 1500);
		chkb({3'h0, slowClkSelXtal, slowXtalOscEn, slowXtalPinsOsc, slowXtalPinPullup, slowRcEn}, 8'h1c);
		look(8'h08, 32'h80, 32'h80, 0);
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h04, 32'h0);
		chkb({6'h0, slowClkSelXtal, slowOscBypass}, 8'h3);
		bus(1'b1, 8'h0c, 32'h0);
		chkb({6'h0, fastRcEn, mainXtalEn}, 8'h0);
		rstPulse(1'b1, 1'b0);
		look(8'h18, 32'hffffffff, 32'h0, 0);
		chkb({7'h0, slowClkSelXtal}, 8'h1);
		rstPulse(1'b0, 1'b1);
		chkb({5'h0, slowRcEn, slowClkSelXtal, slowXtalPinPullup}, 8'h05);
	endtask

	// ****************************************
	// Main sequence and verdict
	// ****************************************
	task automatic close_out;
		if (miscompares == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		supplyRst_n = 1'b0;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'hf;
		dat_i = 32'h0;
		factoryTrimLow = 7'h05;
		factoryTrimMid = 7'h0a;
		factoryTrimHigh = 7'h0c;
		miscompares = 0;
		comparisons = 0;
		rstPulse(1'b1, 1'b1);
		tReset;
		tTrim;
		tRcOff;
		tXtal;
		tSlow;
		close_out;
	end

	// Hang guard, well beyond the longest crystal start-up waits
	initial
	begin
		repeat (60000) @(posedge clk);
		miscompares++;
		close_out;
	end
endmodule
`default_nettype wire
